// file: src/xeu_exec.sv
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "xeu_regs.svh"
// Summary of operation
// - add with carry into accumulator, four flags
// - add with carry into memory, four flags
// - plain add memory or immediate to accumulator
// - plain add into memory, accumulator kept
// - and into accumulator, zero flag only
// - and into memory, zero flag only
// - call pushes next address, loads target
// - clear byte to zero, flags kept
// - clear one bit, others and flags kept
// - watchdog restart clears counter and both flags
// - both preclears needed to clear watchdog
// - single preclear only sets its marker
// - invert byte in place, zero flag only
// - inverted byte to accumulator, memory kept
// - bcd low nibble adjust carries into high nibble, nibble carry kept
// - bcd high nibble adjust, carry, to memory
// - decrement to memory or accumulator, zero flag
// - increment to memory or accumulator, zero flag
// - halt stops execution, state kept, pc advances
// - halt clears watchdog, sets power-down flag
// - jump loads target into program counter
// - pc low write or jump costs extra cycle
module xeu_exec (
  input  wire logic        clk,     // system clock
  input  wire logic        reset,   // sync, active high
  input  wire logic        psel,    // apb select
  input  wire logic        penable, // apb enable
  input  wire logic        pwrite,  // apb direction
  input  wire logic [7:0]  paddr,   // apb byte address
  input  wire logic [31:0] pwdata,  // apb write data
  output logic      [31:0] prdata,  // apb read data
  output logic             pready,  // apb ready
  output logic             pslverr  // apb error
);
  logic [7:0]        acc, next_acc;
  xeu_pkg::xeu_flags_t flg, next_flg;
  logic [11:0]       pc, next_pc;
  logic [7:0]        mem [`XEU_MEM_N];
  logic [7:0]        next_mem [`XEU_MEM_N];
  logic [11:0]       stk [`XEU_STK_N];
  logic [11:0]       next_stk [`XEU_STK_N];
  logic [2:0]        sp, next_sp;
  logic [7:0]        wdt, next_wdt;
  logic [7:0]        pre, next_pre;
  logic              mark1, next_mark1;
  logic              mark2, next_mark2;
  logic              halted, next_halted;
  logic [3:0]        busy, next_busy;
  logic [3:0]        midx, next_midx;
  logic [31:0]       next_prdata;
  logic              next_pready, next_pslverr;

  logic              wr_done, setup_acc, stall, cmd_go, decoded;
  xeu_pkg::xeu_op_t  op;
  logic [7:0]        mval, imm;
  logic [3:0]        madr;
  logic [2:0]        bsel;
  logic [11:0]       tgt;

  function automatic xeu_pkg::xeu_alu_t add8(input logic [7:0] a,
      input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    add8.sum = s[7:0];
    add8.c   = s[8];
    add8.ac  = h[4];
    add8.ov  = (a[7] == b[7]) && (s[7] != a[7]);
  endfunction : add8

  function automatic logic [7:0] mem_rd(input logic [3:0] i,
      input logic [11:0] p);
    // index of the pc low byte reads the live program counter
    mem_rd = (i == `XEU_PCL_IDX) ? p[7:0] : mem[i];
  endfunction : mem_rd

  function automatic logic is_map(input logic [7:0] a);
    is_map = (a == `XEU_A_CMD) || (a == `XEU_A_ACC) ||
             (a == `XEU_A_FLAGS) || (a == `XEU_A_PC) ||
             (a == `XEU_A_MDATA) || (a == `XEU_A_MIDX) ||
             (a == `XEU_A_STAT) || (a == `XEU_A_WAKE);
  endfunction : is_map

  assign op        = xeu_pkg::xeu_op_t'(pwdata[`XEU_F_OP]);
  assign bsel      = pwdata[`XEU_F_BIT];
  assign imm       = pwdata[`XEU_F_IMM];
  assign madr      = pwdata[`XEU_F_MADR];
  assign tgt       = pwdata[`XEU_F_TGT];
  // a process, so that writes into the memory array also refresh it
  always_comb mval = mem_rd(madr, pc);
  assign decoded   = pwdata[`XEU_F_OP] <= 5'(xeu_pkg::direct_jump);
  assign setup_acc = psel && penable && !pready;
  assign wr_done   = psel && penable && pready && pwrite && !pslverr;
  // a new command waits in the access phase until the last one is done
  assign stall     = pwrite && (paddr == `XEU_A_CMD) && (busy != 4'h0);
  assign cmd_go    = wr_done && (paddr == `XEU_A_CMD);

  always_comb begin
    xeu_pkg::xeu_alu_t r;
    logic [7:0]        res;
    logic              mw, aw, zu, ac1;
    logic [4:0]        lo, hi;
    r = '0;
    res = `XEU_B_RST;
    mw = 1'b0;
    aw = 1'b0;
    zu = 1'b0;
    ac1 = 1'b0;
    lo = 5'h00;
    hi = 5'h00;
    next_acc = acc;
    next_flg = flg;
    next_pc = pc;
    next_mem = mem;
    next_stk = stk;
    next_sp = sp;
    next_wdt = wdt;
    next_pre = pre;
    next_mark1 = mark1;
    next_mark2 = mark2;
    next_halted = halted;
    next_busy = (busy != 4'h0) ? busy - 4'h1 : busy;
    next_midx = midx;
    if (!halted) begin
      next_pre = pre + 8'h01;
      if (pre == 8'hFF)
        next_wdt = wdt + 8'h01;
    end
    if (cmd_go && decoded) begin
      next_pc = pc + 12'h001;
      next_busy = `XEU_CYC_ONE;
      case (op)
        xeu_pkg::op_adc_acc, xeu_pkg::add_carry_into_memory: begin
          r = add8(acc, mval, flg.c);
          res = r.sum;
          aw = (op == xeu_pkg::op_adc_acc);
          mw = !aw;
        end
        xeu_pkg::op_add_acc, xeu_pkg::sum_into_memory: begin
          r = add8(acc, mval, 1'b0);
          res = r.sum;
          aw = (op == xeu_pkg::op_add_acc);
          mw = !aw;
        end
        xeu_pkg::op_add_imm: begin
          r = add8(acc, imm, 1'b0);
          res = r.sum;
          aw = 1'b1;
        end
        xeu_pkg::op_and_acc: begin
          res = acc & mval;
          aw = 1'b1;
          zu = 1'b1;
        end
        xeu_pkg::op_and_imm: begin
          res = acc & imm;
          aw = 1'b1;
          zu = 1'b1;
        end
        xeu_pkg::conjunction_into_memory: begin
          res = acc & mval;
          mw = 1'b1;
          zu = 1'b1;
        end
        xeu_pkg::op_call: begin
          next_stk[sp] = pc + 12'h001;
          next_sp = sp + 3'h1;
          next_pc = tgt;
          next_busy = `XEU_CYC_TWO;
        end
        xeu_pkg::direct_jump: begin
          next_pc = tgt;
          next_busy = `XEU_CYC_TWO;
        end
        xeu_pkg::op_clr_mem: begin
          res = `XEU_B_RST;
          mw = 1'b1;
        end
        xeu_pkg::op_clr_bit: begin
          res = mval & ~(8'h01 << bsel);
          mw = 1'b1;
        end
        xeu_pkg::watchdog_restart: begin
          next_wdt = `XEU_B_RST;
          next_pre = `XEU_B_RST;
          next_flg.power_down_flag = 1'b0;
          next_flg.watchdog_expiry_flag = 1'b0;
          next_mark1 = 1'b0;
          next_mark2 = 1'b0;
        end
        xeu_pkg::watchdog_preclear_first,
        xeu_pkg::watchdog_preclear_second: begin
          if ((op == xeu_pkg::watchdog_preclear_first) ? mark2 : mark1)
          begin
            next_wdt = `XEU_B_RST;
            next_pre = `XEU_B_RST;
            next_flg.power_down_flag = 1'b0;
            next_flg.watchdog_expiry_flag = 1'b0;
            next_mark1 = 1'b0;
            next_mark2 = 1'b0;
          end else if (op == xeu_pkg::watchdog_preclear_first) begin
            next_mark1 = 1'b1;
          end else begin
            next_mark2 = 1'b1;
          end
        end
        xeu_pkg::invert_bits_in_place: begin
          res = ~mval;
          mw = 1'b1;
          zu = 1'b1;
        end
        xeu_pkg::invert_bits_to_acc: begin
          res = ~mval;
          aw = 1'b1;
          zu = 1'b1;
        end
        xeu_pkg::bcd_adjust: begin
          lo = {1'b0, acc[3:0]};
          if ((acc[3:0] > `XEU_BCD_LIM) || flg.half_carry_flag) begin
            lo = lo + {1'b0, `XEU_BCD_ADD};
            ac1 = !flg.half_carry_flag;
          end
          hi = {1'b0, acc[7:4]} + {4'h0, ac1};
          if ((hi > {1'b0, `XEU_BCD_LIM}) || flg.c) begin
            hi = hi + {1'b0, `XEU_BCD_ADD};
            next_flg.c = 1'b1;
          end
          res = {hi[3:0], lo[3:0]};
          mw = 1'b1;
        end
        xeu_pkg::minus_one_in_place, xeu_pkg::minus_one_to_acc: begin
          res = mval - 8'h01;
          aw = (op == xeu_pkg::minus_one_to_acc);
          mw = !aw;
          zu = 1'b1;
        end
        xeu_pkg::op_inc_mem, xeu_pkg::plus_one_to_acc: begin
          res = mval + 8'h01;
          aw = (op == xeu_pkg::plus_one_to_acc);
          mw = !aw;
          zu = 1'b1;
        end
        xeu_pkg::op_halt: begin
          next_halted = 1'b1;
          next_wdt = `XEU_B_RST;
          next_pre = `XEU_B_RST;
          next_flg.power_down_flag = 1'b1;
          next_flg.watchdog_expiry_flag = 1'b0;
        end
        default: begin
        end
      endcase
      if (r != '0 || op == xeu_pkg::op_adc_acc ||
          op == xeu_pkg::add_carry_into_memory ||
          op == xeu_pkg::op_add_acc || op == xeu_pkg::op_add_imm ||
          op == xeu_pkg::sum_into_memory) begin
        next_flg.c = r.c;
        next_flg.half_carry_flag = r.ac;
        next_flg.signed_range_flag = r.ov;
        zu = 1'b1;
      end
      if (zu)
        next_flg.z = (res == 8'h00);
      if (aw)
        next_acc = res;
      if (mw && madr == `XEU_PCL_IDX) begin
        next_pc = {pc[11:8], res};
        next_busy = `XEU_CYC_TWO;
      end else if (mw) begin
        next_mem[madr] = res;
      end
    end
    if (wr_done) begin
      case (paddr)
        `XEU_A_ACC:   next_acc = pwdata[7:0];
        `XEU_A_FLAGS: next_flg = pwdata[5:0];
        `XEU_A_MIDX:  next_midx = pwdata[3:0];
        `XEU_A_MDATA: begin
          if (midx == `XEU_PCL_IDX)
            next_pc = {pc[11:8], pwdata[7:0]};
          else
            next_mem[midx] = pwdata[7:0];
        end
        `XEU_A_WAKE:  next_halted = 1'b0;
        default: begin
        end
      endcase
    end
    // expiry set wins over any clear in the same cycle
    if (!halted && pre == 8'hFF && wdt == 8'hFF)
      next_flg.watchdog_expiry_flag = 1'b1;
  end

  always_comb begin
    next_pready = setup_acc && !stall;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (setup_acc && !stall) begin
      next_pslverr = !is_map(paddr) ||
        (pwrite && paddr == `XEU_A_CMD &&
         (halted || !decoded));
      if (!pwrite) begin
        case (paddr)
          `XEU_A_ACC:   next_prdata = {24'h000000, acc};
          `XEU_A_FLAGS: next_prdata = {26'h0000000, flg};
          `XEU_A_PC:    next_prdata = {20'h00000, pc};
          `XEU_A_MDATA: next_prdata = {24'h000000, mem_rd(midx, pc)};
          `XEU_A_MIDX:  next_prdata = {28'h0000000, midx};
          `XEU_A_STAT:  next_prdata = {8'h00, wdt, 5'h00, sp,
                                       mark2, mark1, halted,
                                       busy != 4'h0, busy};
          default:      next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc <= `XEU_B_RST;
      flg <= '0;
      pc <= `XEU_PC_RST;
      sp <= 3'h0;
      wdt <= `XEU_B_RST;
      pre <= `XEU_B_RST;
      mark1 <= 1'b0;
      mark2 <= 1'b0;
      halted <= 1'b0;
      busy <= 4'h0;
      midx <= 4'h0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      for (int i = 0; i < `XEU_MEM_N; i++)
        mem[i] <= `XEU_B_RST;
      for (int i = 0; i < `XEU_STK_N; i++)
        stk[i] <= `XEU_PC_RST;
    end else begin
      acc <= next_acc;
      flg <= next_flg;
      pc <= next_pc;
      sp <= next_sp;
      wdt <= next_wdt;
      pre <= next_pre;
      mark1 <= next_mark1;
      mark2 <= next_mark2;
      halted <= next_halted;
      busy <= next_busy;
      midx <= next_midx;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      mem <= next_mem;
      stk <= next_stk;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_long_busy: assert property (cmd_go && op == xeu_pkg::direct_jump
    |=> busy == `XEU_CYC_TWO ##4 busy == 4'h4)
    else $error("jump did not take two instruction cycles");
  a_clear_byte: assert property (cmd_go && op == xeu_pkg::op_clr_mem
    && madr != `XEU_PCL_IDX |=> mem[$past(madr)] == 8'h00
    && flg == $past(flg))
    else $error("byte clear wrong or flags moved");
  a_and_acc: assert property (cmd_go && op == xeu_pkg::op_and_acc
    |=> acc == ($past(acc) & $past(mval)) && flg.c == $past(flg.c)
    && flg.z == (acc == 8'h00))
    else $error("and into accumulator wrong");
  a_call_push: assert property (cmd_go && op == xeu_pkg::op_call
    |=> pc == $past(tgt) && stk[$past(sp)] == 12'($past(pc) + 12'h001))
    else $error("call did not push next address");
  a_wdt_restart: assert property (cmd_go && op == xeu_pkg::watchdog_restart
    |=> wdt == 8'h00 && !flg.power_down_flag)
    else $error("watchdog restart incomplete");
  a_pre_single: assert property (cmd_go
    && op == xeu_pkg::watchdog_preclear_first && !mark2
    |=> mark1 && flg.power_down_flag == $past(flg.power_down_flag))
    else $error("single preclear changed state");
  a_halt_entry: assert property (cmd_go && op == xeu_pkg::op_halt
    |=> halted && flg.power_down_flag && wdt == 8'h00
    && pc == 12'($past(pc) + 12'h001))
    else $error("halt entry wrong");
  a_halt_frozen: assert property (halted && !wr_done
    |=> $stable(pc) && $stable(acc) && $stable(wdt))
    else $error("state moved while halted");
  a_inc_acc: assert property (cmd_go && op == xeu_pkg::plus_one_to_acc
    |=> acc == 8'($past(mval) + 8'h01) && flg.c == $past(flg.c))
    else $error("increment to accumulator wrong");
  a_add_carry: assert property (cmd_go && op == xeu_pkg::op_add_imm
    |=> flg.c == ((9'($past(acc)) + 9'($past(imm))) > 9'h0FF))
    else $error("carry out of bit 7 wrong");

  c_call: cover property (cmd_go && op == xeu_pkg::op_call);
  c_bcd: cover property (cmd_go && op == xeu_pkg::bcd_adjust && flg.c);
  c_halt: cover property (cmd_go && op == xeu_pkg::op_halt);
  c_both_pre: cover property (cmd_go
    && op == xeu_pkg::watchdog_preclear_second && mark1);
endmodule : xeu_exec

// file: src/xeu_regs.svh
`ifndef XEU_REGS_SVH
`define XEU_REGS_SVH
`define XEU_A_CMD    8'h00
`define XEU_A_ACC    8'h04
`define XEU_A_FLAGS  8'h08
`define XEU_A_PC     8'h0C
`define XEU_A_MDATA  8'h10
`define XEU_A_MIDX   8'h14
`define XEU_A_STAT   8'h18
`define XEU_A_WAKE   8'h1C
`define XEU_F_OP     4:0
`define XEU_F_BIT    7:5
`define XEU_F_IMM    15:8
`define XEU_F_MADR   19:16
`define XEU_F_TGT    31:20
`define XEU_CYC_ONE  4'h4
`define XEU_CYC_TWO  4'h8
`define XEU_MEM_N    16
`define XEU_STK_N    8
`define XEU_PCL_IDX  4'h0
`define XEU_BCD_LIM  4'h9
`define XEU_BCD_ADD  4'h6
`define XEU_PC_RST   12'h000
`define XEU_B_RST    8'h00
`endif

// file: src/xeu_pkg.sv
package xeu_pkg;
  typedef enum logic [4:0] {
    op_nop, op_adc_acc, add_carry_into_memory, op_add_acc, op_add_imm,
    sum_into_memory, op_and_acc, op_and_imm, conjunction_into_memory,
    op_call, op_clr_mem, op_clr_bit, watchdog_restart,
    watchdog_preclear_first, watchdog_preclear_second,
    invert_bits_in_place, invert_bits_to_acc, bcd_adjust,
    minus_one_in_place, minus_one_to_acc, op_inc_mem, plus_one_to_acc,
    op_halt, direct_jump
  } xeu_op_t;
  typedef struct packed {
    logic watchdog_expiry_flag;
    logic power_down_flag;
    logic signed_range_flag;
    logic z;
    logic half_carry_flag;
    logic c;
  } xeu_flags_t;
  typedef struct packed {
    logic [7:0] sum;
    logic       c;
    logic       ac;
    logic       ov;
  } xeu_alu_t;
endpackage : xeu_pkg

// file: bench/mcu_instruction_execute_unit_tb.sv
`timescale 1ns/1ps
`include "xeu_regs.svh"
module mcu_instruction_execute_unit_tb;
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_errors;
  int          n_checks;
  int          cyc;
  int          macc;
  int          mfl;
  int          mm [16];
  int          m1;
  int          m2;
  int          ncall;

  xeu_exec u_dut (
    .clk     (clk),
    .reset   (reset),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  always #50 clk = ~clk;
  // counted on the falling edge so reads never race it
  always @(negedge clk) cyc++;

  task automatic tally_and_finish();
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", nm, x, g);
      n_errors++;
    end
  endtask : chk

  // entered just after a rising edge; one idle cycle after each transfer
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    // ready, data and error are taken at the edge that sees ready high
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string nm);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask : rd

  task automatic wait_idle();
    logic [31:0] q;
    logic        e;
    int          k;
    k = 0;
    do begin
      apb(1'b0, `XEU_A_STAT, 32'h0, q, e);
      k++;
    end while (q[4] !== 1'b0 && k < 20);
    if (k >= 20) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : wait_idle

  function automatic logic [31:0] cw(input int op, input int b,
                                     input int im, input int ma,
                                     input int tg);
    return {tg[11:0], ma[3:0], im[7:0], b[2:0], op[4:0]};
  endfunction : cw

  task automatic mdl(input int op, input int b, input int im,
                     input int ma, input int tg);
    int v;
    int s;
    int r;
    int lo;
    int hi;
    int a1;
    v = (op == 4 || op == 7) ? im : mm[ma];
    r = -1;
    case (op)
      1, 2, 3, 4, 5: begin
        a1 = (op <= 2) ? mfl[0] : 0;
        s = macc + v + a1;
        mfl[0] = s[8];
        mfl[1] = ((macc & 15) + (v & 15) + a1) > 15;
        mfl[3] = (macc[7] == v[7]) && (s[7] != macc[7]);
        r = s & 255;
      end
      6, 7, 8: r = macc & v;
      9: ncall++;
      10: mm[ma] = 0;
      11: mm[ma] = v & ~(1 << b);
      12: begin
        mfl[5:4] = 0;
        m1 = 0;
        m2 = 0;
      end
      13, 14: begin
        if (op == 13) m1 = 1;
        else m2 = 1;
        if (m1 && m2) begin
          mfl[5:4] = 0;
          m1 = 0;
          m2 = 0;
        end
      end
      15, 16: r = ~v & 255;
      17: begin
        lo = macc & 15;
        hi = (macc >> 4) & 15;
        a1 = 0;
        if (lo > 9 || mfl[1]) begin
          lo = (lo + 6) & 15;
          a1 = !mfl[1];
        end
        if (hi + a1 > 9 || mfl[0]) begin
          hi = (hi + 6 + a1) & 15;
          mfl[0] = 1;
        end else begin
          hi = (hi + a1) & 15;
        end
        mm[ma] = hi * 16 + lo;
      end
      18, 19: r = (v - 1) & 255;
      20, 21: r = (v + 1) & 255;
      22: begin
        mfl[4] = 1;
        mfl[5] = 0;
      end
      default: ;
    endcase
    if (r >= 0) begin
      mfl[2] = (r == 0);
      if (op inside {2, 5, 8, 15, 18, 20}) mm[ma] = r;
      else macc = r;
    end
  endtask : mdl

  task automatic run(input int op, input int b, input int im,
                     input int ma, input int tg);
    logic [31:0] q;
    logic        e;
    mdl(op, b, im, ma, tg);
    apb(1'b1, `XEU_A_CMD, cw(op, b, im, ma, tg), q, e);
    chk("cmd_err", 32'h0, {31'h0, e});
    wait_idle();
    rd(`XEU_A_ACC, macc, "acc");
    rd(`XEU_A_FLAGS, mfl & 63, "flags");
    wr(`XEU_A_MIDX, ma);
    rd(`XEU_A_MDATA, mm[ma], "mem");
  endtask : run

  initial begin
    logic [31:0] q;
    logic        e;
    int          ops [4];
    int          mas [4];
    int          base;
    int          t0;
    int          ma;
    clk = 1'b0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ops = '{20, 9, 23, 10};
    mas = '{1, 1, 1, 0};
    void'($urandom(32'h92CFB46F));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(`XEU_A_ACC, 32'h0, "acc_rst");
    rd(`XEU_A_FLAGS, 32'h0, "flags_rst");
    rd(`XEU_A_PC, 32'h0, "pc_rst");
    apb(1'b0, `XEU_A_STAT, 32'h0, q, e);
    chk("stat_rst", 32'h0, q & 32'h0000FFFF);
    for (int op = 0; op < 22; op++) begin
      for (int it = 0; it < 3; it++) begin
        if (op == 9) continue;
        // restart first so a lone preclear sees no partner marker
        if (op == 13 || op == 14) run(12, 0, 0, 1, 0);
        ma = 1 + $urandom % 15;
        macc = (it == 0) ? 255 : $urandom & 255;
        mfl = (it == 0) ? 0 : $urandom & 63;
        mm[ma] = (it == 0) ? 1 : $urandom & 255;
        wr(`XEU_A_ACC, macc);
        wr(`XEU_A_FLAGS, mfl);
        wr(`XEU_A_MIDX, ma);
        wr(`XEU_A_MDATA, mm[ma]);
        run(op, $urandom % 8, $urandom & 255, ma, 0);
      end
    end
    run(12, 0, 0, 1, 0);
    apb(1'b0, `XEU_A_STAT, 32'h0, q, e);
    chk("wdt_restart", 32'h1, {31'h0, q[23:16] < 8'h02});
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    apb(1'b1, `XEU_A_CMD, cw(31, 0, 0, 1, 0), q, e);
    chk("badop_err", 32'h1, {31'h0, e});
    wr(`XEU_A_FLAGS, 32'h30);
    mfl = 32'h30;
    run(13, 0, 0, 2, 0);
    apb(1'b0, `XEU_A_STAT, 32'h0, q, e);
    chk("mark_first", 32'h1, {31'h0, q[6]});
    run(14, 0, 0, 2, 0);
    apb(1'b0, `XEU_A_STAT, 32'h0, q, e);
    chk("wdt_pair", 32'h1, {31'h0, q[23:16] < 8'h02});
    for (int i = 0; i < 4; i++) begin
      wait_idle();
      mdl(ops[i], 0, 0, mas[i], 12'h100);
      apb(1'b1, `XEU_A_CMD, cw(ops[i], 0, 0, mas[i], 12'h100), q, e);
      t0 = cyc;
      apb(1'b1, `XEU_A_CMD, cw(0, 0, 0, 0, 0), q, e);
      if (i == 0) base = cyc - t0;
      else chk("stall", base + 4, cyc - t0);
    end
    run(23, 0, 0, 1, 12'h5A3);
    rd(`XEU_A_PC, 32'h5A3, "pc_jump");
    run(9, 0, 0, 1, 12'h2C4);
    rd(`XEU_A_PC, 32'h2C4, "pc_call");
    apb(1'b0, `XEU_A_STAT, 32'h0, q, e);
    chk("stack_ptr", ncall & 7, q[10:8]);
    run(22, 0, 0, 3, 0);
    rd(`XEU_A_PC, 32'h2C5, "pc_halt");
    apb(1'b0, `XEU_A_STAT, 32'h0, q, e);
    chk("halted", 32'h1, {31'h0, q[5]});
    chk("wdt_halt", 32'h0, q[23:16]);
    apb(1'b1, `XEU_A_CMD, cw(21, 0, 0, 3, 0), q, e);
    chk("halt_refuse", 32'h1, {31'h0, e});
    wr(`XEU_A_WAKE, 32'h1);
    apb(1'b0, `XEU_A_STAT, 32'h0, q, e);
    chk("woken", 32'h0, {31'h0, q[5]});
    run(21, 0, 0, 3, 0);
    tally_and_finish();
  end
endmodule : mcu_instruction_execute_unit_tb
